// file: shared/self_test_pkg.sv
// Purpose: shared constants and carriers of the serial link self test
// Assumes: one 100 MHz clock, byte addresses on the register bus
// Notes: all register fields sit in the low byte lane
package self_test_pkg;
    localparam int PAY_W = 35;
    localparam int CNT_W_DEF = 8;
    localparam int IRQ_W = 3;

    // register byte offsets
    localparam logic [5:0] OFF_LOCAL_CTL = 6'h04;
    localparam logic [5:0] OFF_LINK_STS = 6'h0C;
    localparam logic [5:0] OFF_TEST_CRC = 6'h10;
    localparam logic [5:0] OFF_FUNC_CRC = 6'h14;
    localparam logic [5:0] OFF_IRQ_STS = 6'h18;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h1C;

    // field positions
    localparam int RESTART_BIT = 5;
    localparam int LINK_LOCK_BIT = 0;
    localparam int TEST_ACT_BIT = 1;
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_CRC = 2;

    // reset values
    localparam logic [PAY_W-1:0] LFSR_SEED = 35'h0_0000_0001;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [7:0] DISP_RST = 8'h00;

    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
        logic [23:0] rgb;
    } video_t;

    typedef struct packed {
        logic valid;
        logic test_en;
        logic crc_err;
    } bc_frame_t;

    typedef struct packed {
        logic [PAY_W-1:0] payload;
        logic inv;
    } tx_frame_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;
endpackage

// file: src/serial_link_self_test.sv
// Purpose: serializer side of the at-speed link self test
// Assumes: back channel receiver delivers decoded frames and a lock level
// Notes: Avalon-MM slave with one wait state on every access
//
// How it works
// - far end starts the test and sends a test-enable bit in back channel frames.
// - in test, video inputs are frozen and scrambled, balanced zeros are sent.
// - test lasts as long as the far test-enable pin is held and back channel lock stays up; lock loss ends it.
// - link lock stays valid for the whole test.
// - back channel CRC checked only after back channel lock, seen at 0x0C bit 0.
// - 8-bit CRC count cleared on test entry; functional count restarts then.
// - test CRC count runs only in test and keeps last run's total.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
module serial_link_self_test
    import self_test_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire video_t video_in,
    input wire bc_frame_t bc_frame,
    input wire logic bc_lock,
    output tx_frame_t tx_frame,
    output logic tx_valid,
    output logic test_active,
    output logic irq
);
    generate
        if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt
            $error("CNT_W must be 1 to 8");
        end
    endgenerate

    function automatic logic [7:0] ones_of(input logic [PAY_W-1:0] w);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < PAY_W; i++) begin
            n = n + {7'h00, w[i]};
        end
        return n;
    endfunction

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // state
    bus_state_t bus_reg, bus_next;
    logic [31:0] rdata_reg, rdata_next;
    logic test_reg, test_next;
    logic lock_reg;
    logic restart_reg;
    video_t video_reg;
    logic [PAY_W-1:0] lfsr_reg, lfsr_next;
    logic signed [7:0] disp_reg, disp_next;
    tx_frame_t tx_reg, tx_next;
    logic txv_reg;
    logic [CNT_W-1:0] test_crc_reg, test_crc_next;
    logic [CNT_W-1:0] func_crc_reg, func_crc_next;
    logic [IRQ_W-1:0] sts_reg, sts_next;
    logic [IRQ_W-1:0] mask_reg;
    logic irq_reg;
    logic wait_reg;

    // bus decode
    wire wr_take = avs_write && bus_reg == BUS_ACK && avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire hit_local = avs_address == OFF_LOCAL_CTL;
    wire hit_sts = avs_address == OFF_LINK_STS;
    wire hit_tcrc = avs_address == OFF_TEST_CRC;
    wire hit_fcrc = avs_address == OFF_FUNC_CRC;
    wire hit_irqs = avs_address == OFF_IRQ_STS;
    wire hit_mask = avs_address == OFF_IRQ_MASK;
    // irq looks at the new mask so it never lags a mask write
    wire [IRQ_W-1:0] mask_next = (wr_take && hit_mask) ? wbyte[IRQ_W-1:0] : mask_reg;

    // link events
    wire bc_ok = bc_frame.valid && lock_reg;
    wire crc_hit = bc_ok && bc_frame.crc_err;
    wire test_rise = test_next && !test_reg;
    wire test_fall = !test_next && test_reg;

    // pattern path
    wire restart_wr = wr_take && hit_local && wbyte[RESTART_BIT];
    wire [PAY_W-1:0] video_word = {{(PAY_W - $bits(video_t)){1'b0}}, video_reg};
    wire [PAY_W-1:0] src_word = test_reg ? {PAY_W{1'b0}} : video_word;
    wire [PAY_W-1:0] scr_word = src_word ^ lfsr_reg;
    wire [7:0] ones = ones_of(scr_word);
    wire signed [7:0] excess = $signed(ones) + $signed(ones) - 8'sd35;
    wire flip = (disp_reg > 0 && excess > 0) || (disp_reg < 0 && excess < 0);
    wire lfsr_fb = lfsr_reg[PAY_W-1] ^ lfsr_reg[PAY_W-3];
    wire [IRQ_W-1:0] events = {crc_hit, test_fall, test_rise};

    // bus state machine: one wait state, answer at second edge
    always_comb begin
        bus_next = bus_reg;
        rdata_next = rdata_reg;
        case (bus_reg)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_next = BUS_ACK;
                end
                rdata_next = 32'h0000_0000;
                if (hit_local) begin
                    rdata_next[RESTART_BIT] = restart_reg;
                end else if (hit_sts) begin
                    rdata_next[LINK_LOCK_BIT] = lock_reg;
                    rdata_next[TEST_ACT_BIT] = test_reg;
                end else if (hit_tcrc) begin
                    rdata_next[CNT_W-1:0] = test_crc_reg;
                end else if (hit_fcrc) begin
                    rdata_next[CNT_W-1:0] = func_crc_reg;
                end else if (hit_irqs) begin
                    rdata_next[IRQ_W-1:0] = sts_reg;
                end else if (hit_mask) begin
                    rdata_next[IRQ_W-1:0] = mask_reg;
                end
            end
            BUS_ACK: begin
                bus_next = BUS_IDLE;
            end
            default: begin
                bus_next = BUS_IDLE;
            end
        endcase
    end

    // test enable follows each locked back channel frame
    always_comb begin
        test_next = test_reg;
        if (!lock_reg) begin
            test_next = 1'b0;
        end else if (bc_frame.valid) begin
            test_next = bc_frame.test_en;
        end
    end

    // error counters; count wins over a software clear
    always_comb begin
        test_crc_next = test_crc_reg;
        func_crc_next = func_crc_reg;
        if (wr_take && hit_tcrc) begin
            test_crc_next = '0;
        end
        if (wr_take && hit_fcrc) begin
            func_crc_next = '0;
        end
        if (test_rise) begin
            test_crc_next = '0;
            func_crc_next = '0;
        end
        if (crc_hit && test_reg && test_next && test_crc_next != CNT_MAX) begin
            test_crc_next = test_crc_next + 1'b1;
        end
        if (crc_hit && func_crc_next != CNT_MAX) begin
            func_crc_next = func_crc_next + 1'b1;
        end
    end

    // scrambler restarts on the host pulse so both ends realign
    always_comb begin
        lfsr_next = {lfsr_reg[PAY_W-2:0], lfsr_fb};
        if (restart_wr) begin
            lfsr_next = LFSR_SEED;
        end
        tx_next.payload = flip ? ~scr_word : scr_word;
        tx_next.inv = flip;
        disp_next = flip ? disp_reg - excess : disp_reg + excess;
    end

    // sticky status: a new event beats the write-one clear
    always_comb begin
        sts_next = sts_reg;
        if (wr_take && hit_irqs) begin
            sts_next = sts_reg & ~wbyte[IRQ_W-1:0];
        end
        sts_next = sts_next | events;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_reg <= BUS_IDLE;
            rdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b1;
        end else begin
            bus_reg <= bus_next;
            rdata_reg <= rdata_next;
            wait_reg <= bus_next != BUS_ACK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            test_reg <= 1'b0;
            lock_reg <= 1'b0;
            video_reg <= '0;
        end else begin
            test_reg <= test_next;
            lock_reg <= bc_lock;
            if (!test_reg) begin
                video_reg <= video_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lfsr_reg <= LFSR_SEED;
            disp_reg <= DISP_RST;
            tx_reg <= '0;
            txv_reg <= 1'b0;
        end else begin
            lfsr_reg <= lfsr_next;
            disp_reg <= disp_next;
            tx_reg <= tx_next;
            txv_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            test_crc_reg <= '0;
            func_crc_reg <= '0;
        end else begin
            test_crc_reg <= test_crc_next;
            func_crc_reg <= func_crc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            restart_reg <= 1'b0;
            sts_reg <= '0;
            mask_reg <= IRQ_MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            if (wr_take && hit_local) begin
                restart_reg <= wbyte[RESTART_BIT];
            end
            mask_reg <= mask_next;
            sts_reg <= sts_next;
            irq_reg <= |(sts_next & mask_next);
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign tx_frame = tx_reg;
    assign tx_valid = txv_reg;
    assign test_active = test_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_enable_follow: assert property (
        bc_frame.valid && lock_reg |=> test_reg == $past(bc_frame.test_en)
    ) else $error("test state did not follow back channel enable");

    chk_video_frozen: assert property (
        test_reg [*2] |-> $stable(video_reg)
    ) else $error("video sampled during test");

    chk_zero_pattern: assert property (
        test_reg |=> tx_reg.payload == ($past(lfsr_reg) ^ {PAY_W{tx_reg.inv}})
    ) else $error("test frame is not scrambled zeros");

    chk_lock_kept: assert property (
        test_reg |-> tx_valid && $past(tx_valid)
    ) else $error("link dropped during test");

    chk_crc_gate: assert property (
        !lock_reg && !wr_take && !test_rise |=> $stable(func_crc_reg)
    ) else $error("crc counted without back channel lock");

    chk_entry_clear: assert property (
        $rose(test_reg) |-> test_crc_reg == '0 && func_crc_reg == CNT_W'($past(crc_hit))
    ) else $error("counters not cleared at test entry");

    chk_test_cnt_hold: assert property (
        !test_reg && !(wr_take && hit_tcrc) |=>
            test_crc_reg == ($past(test_rise) ? {CNT_W{1'b0}} : $past(test_crc_reg))
    ) else $error("test crc count changed outside test");

    chk_resume_video: assert property (
        $fell(test_reg) ##1 !test_reg |=>
            tx_reg.payload == ($past(video_word) ^ $past(lfsr_reg) ^ {PAY_W{tx_reg.inv}})
    ) else $error("video not resumed after test");

    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("bus answer not one wait state");

    chk_irq_level: assert property (
        irq_reg == |(sts_reg & mask_reg)
    ) else $error("interrupt low with unmasked status");

    cov_test_run: cover property ($rose(test_reg) ##[1:50] $fell(test_reg));
    cov_test_crc: cover property (test_reg && crc_hit);
    cov_restart: cover property (test_reg && restart_wr);
    cov_irq: cover property ($rose(irq_reg));
endmodule

// file: tb/bc_partner.sv
// Purpose: far end model, sends back channel frames and checks the zeros stream
// Assumes: shares the serializer clock, frames every PERIOD cycles
// Notes: pass only judged while chk_en is high, after the scrambler reseed
module bc_partner
    import self_test_pkg::*;
#(
    parameter int PERIOD = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic test_req,
    input wire logic crc_req,
    input wire logic lock_req,
    input wire logic chk_en,
    input wire tx_frame_t tx_frame,
    output bc_frame_t bc_frame,
    output logic bc_lock,
    output logic pass
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tick_reg;
    logic [PAY_W-1:0] prev_reg;
    wire logic [PAY_W-1:0] word = tx_frame.payload ^ {PAY_W{tx_frame.inv}};
    wire logic step_ok = word == {prev_reg[PAY_W-2:0], prev_reg[PAY_W-1] ^ prev_reg[PAY_W-3]};
    // frames go out locked or not, so the receiver must ignore them itself
    always @(posedge clk) begin
        if (!resetn) begin
            tick_reg <= 8'h00;
            bc_frame <= '0;
            bc_lock <= 1'b0;
            pass <= 1'b0;
        end else begin
            bc_lock <= lock_req;
            tick_reg <= (tick_reg == 8'(PERIOD - 1)) ? 8'h00 : tick_reg + 8'h01;
            if (tick_reg == 8'h00) begin
                bc_frame <= '{1'b1, test_req, crc_req};
            end else begin
                // idle fields toggle so stale values are never trusted
                bc_frame <= '{1'b0, ~bc_frame.test_en, ~bc_frame.crc_err};
            end
            prev_reg <= word;
            if (test_req && !chk_en) begin
                pass <= 1'b1;
            end else if (test_req && chk_en && !step_ok) begin
                pass <= 1'b0;
            end
        end
    end
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench of the serializer self test block
// Assumes: Avalon-MM single wait state, random video with fixed seed
// Notes: scrambled stream judged by the lfsr successor relation only
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import self_test_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    video_t video_in = '0;
    bc_frame_t bc_frame;
    logic bc_lock, test_active, irq, tx_valid, pass;
    tx_frame_t tx_frame;
    logic test_req = 1'b0;
    logic crc_req = 1'b0;
    logic lock_req = 1'b0;
    logic chk_en = 1'b0;
    logic [31:0] rd;
    logic [PAY_W-1:0] prev, cur;
    int error_cnt = 0;
    int total_checks = 0;
    int k, fails;
    always #5 clk = ~clk;
    serial_link_self_test i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .video_in(video_in), .bc_frame(bc_frame),
        .bc_lock(bc_lock), .tx_frame(tx_frame), .tx_valid(tx_valid),
        .test_active(test_active), .irq(irq));
    bc_partner i_far (.clk(clk), .resetn(resetn), .test_req(test_req), .crc_req(crc_req),
        .lock_req(lock_req), .chk_en(chk_en), .tx_frame(tx_frame), .bc_frame(bc_frame),
        .bc_lock(bc_lock), .pass(pass));
    task end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask
    task frames(input int n);
        repeat (n) @(posedge clk iff bc_frame.valid === 1'b1);
    endtask
    // align to a frame first so the request covers exactly n frames
    task crc(input int n);
        frames(1);
        crc_req <= 1'b1;
        frames(n);
        crc_req <= 1'b0;
    endtask
    function automatic logic [PAY_W-1:0] lfsr_step(input logic [PAY_W-1:0] w);
        return {w[PAY_W-2:0], w[PAY_W-1] ^ w[PAY_W-3]};
    endfunction
    task vid(input int n);
        fails = 0;
        @(posedge clk);
        #1 prev = tx_frame.payload ^ {PAY_W{tx_frame.inv}};
        repeat (n) begin
            @(posedge clk);
            video_in <= video_t'($urandom);
            #1 cur = tx_frame.payload ^ {PAY_W{tx_frame.inv}};
            if (cur !== lfsr_step(prev)) fails++;
            `CHK("tx_valid", 1'b1, tx_valid)
            prev = cur;
        end
    endtask
    initial begin
        #300000;
        error_cnt++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hf62c));
        repeat (8) @(posedge clk);
        `CHK("waitreq_rst", 1'b1, avs_waitrequest)
        `CHK("tx_valid_rst", 1'b0, tx_valid)
        `CHK("active_rst", 1'b0, test_active)
        resetn <= 1'b1;
        @(posedge clk);
        #1 `CHK("tx_valid", 1'b1, tx_valid)
        crc(3);
        rchk("func_unlocked", OFF_FUNC_CRC, 32'h0000_0000);
        rchk("link_unlocked", OFF_LINK_STS, 32'h0000_0000);
        lock_req <= 1'b1;
        frames(2);
        rchk("link_locked", OFF_LINK_STS, 32'h0000_0001);
        k = $urandom_range(9, 1);
        crc(k);
        rchk("func_locked", OFF_FUNC_CRC, 32'(k));
        rchk("unmapped", 6'h3C, 32'h0000_0000);
        avs_byteenable <= 4'h0;
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
        avs_byteenable <= 4'hf;
        rchk("mask", OFF_IRQ_MASK, 32'(IRQ_MASK_RST));
        test_req <= 1'b1;
        frames(2);
        #1 `CHK("active_on", 1'b1, test_active)
        rchk("link_test", OFF_LINK_STS, 32'h0000_0003);
        rchk("test_clr", OFF_TEST_CRC, 32'h0000_0000);
        rchk("func_clr", OFF_FUNC_CRC, 32'h0000_0000);
        rchk("irq_sts", OFF_IRQ_STS, 32'h0000_0005);
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge clk);
        #1 `CHK("irq_on", 1'b1, irq)
        bus(1'b1, OFF_IRQ_STS, 32'h0000_0007);
        repeat (2) @(posedge clk);
        #1 `CHK("irq_off", 1'b0, irq)
        bus(1'b1, OFF_LOCAL_CTL, 32'h0000_0020);
        rchk("restart", OFF_LOCAL_CTL, 32'h0000_0020);
        bus(1'b1, OFF_LOCAL_CTL, 32'h0000_0000);
        chk_en <= 1'b1;
        vid(40);
        `CHK("zeros_stream", 0, fails)
        k = $urandom_range(12, 1);
        crc(k);
        rchk("test_cnt", OFF_TEST_CRC, 32'(k));
        rchk("func_cnt", OFF_FUNC_CRC, 32'(k));
        test_req <= 1'b0;
        frames(2);
        #1 `CHK("active_off", 1'b0, test_active)
        `CHK("far_pass", 1'b1, pass)
        vid(20);
        `CHK("video_back", 1'b1, fails > 0)
        crc(2);
        rchk("test_kept", OFF_TEST_CRC, 32'(k));
        rchk("func_more", OFF_FUNC_CRC, 32'(k + 2));
        test_req <= 1'b1;
        frames(2);
        rchk("test_reclr", OFF_TEST_CRC, 32'h0000_0000);
        lock_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK("lock_loss", 1'b0, test_active)
        end_sim();
    end
endmodule
